// >>> vofc_monitor.sv
// checker: apb handshake and output enable relations of the formatter
`timescale 1ns/10ps
`default_nettype none
module vofc_monitor
    import vofc_pkg::*;
(
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // link side enables
    input wire logic link_clk,
    input wire logic pri_oe,
    input wire logic sec_oe,
    input wire logic ctl_oe,
    input wire logic clk_oe,
    input wire logic spdif_oe,
    input wire logic i2s_oe
);
    logic mapped;
    // only the four aligned words answer without an error
    assign mapped = paddr == vofc_addr(IDX_POL) ||
                    paddr == vofc_addr(IDX_CKFMT) ||
                    paddr == vofc_addr(IDX_TRI) ||
                    paddr == vofc_addr(IDX_STAT);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        psel && penable && pready;
    endsequence
    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup_s |=> answer_s) else $error("no answer after setup");
    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("ready held too long");
    ready_access_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> psel && penable) else $error("ready outside access");
    err_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
        answer_s and !mapped |-> pslverr) else $error("unmapped accepted");
    ok_mapped_a: assert property (@(posedge pclk) disable iff (!presetn)
        answer_s and mapped |-> !pslverr) else $error("mapped refused");
    read_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    tri_global_a: assert property (@(posedge link_clk)
        disable iff (!presetn)
        !ctl_oe |-> !pri_oe && !sec_oe && !spdif_oe && !i2s_oe)
        else $error("output driven while all floated");
    clk_ctl_a: assert property (@(posedge link_clk)
        disable iff (!presetn)
        clk_oe == ctl_oe) else $error("clock and control enables differ");
endmodule // vofc_monitor
bind vofc_top vofc_monitor i_vofc_monitor (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .prdata, .pready, .pslverr, .link_clk, .pri_oe,
    .sec_oe, .ctl_oe, .clk_oe, .spdif_oe, .i2s_oe);
`default_nettype wire

// >>> vofc_pkg.sv
// package: register map, field layout, reset values and formatter types
// Operation
// - display-enable output polarity: 0 active low, 1 active high; resets 1
// - field polarity: 0 low means even; 1 swaps meaning; resets 1
// - green sync pin polarity: 0 active low, 1 active high; resets 1
// - green sync source: slicer, line sync, regenerated, PLL sync; resets 11
// - output clock invert bit, resets 0
// - output clock select: half, 1x, 2x, 90 degree; resets 01
// - pixel bus mode: 444 RGB, 422+DDR, DDR444+DDR, 12-bit 422; resets 00
// - 4:2:2 YCrCb mode drives 16 primary pins, not 24
// - DDR 4:4:4 data changes on both output clock edges
// - primary enable: 1 drives red/green, 0 high impedance; resets 1
// - secondary enable: 1 drives blue DDR YCrCb, 0 high impedance; resets 0
// - three-state bit floats every output except green sync pin; resets 0
// - green sync pin three-state bit, resets 0
// - S/PDIF pins three-state bit, resets 0
// - I2S pins three-state bit, resets 0
// - two-bit drive strength for fast outputs, resets 11
// - frame sync output polarity: 0 active low, 1 active high; resets 1
`default_nettype none
package vofc_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_POL = 10'h024;
    localparam logic [9:0] IDX_CKFMT = 10'h025;
    localparam logic [9:0] IDX_TRI = 10'h026;
    localparam logic [9:0] IDX_STAT = 10'h03F;
    // polarity and clock register fields
    localparam int POL_LINE_BIT = 7;
    localparam int POL_FRAME_BIT = 6;
    localparam int POL_DE_BIT = 5;
    localparam int POL_FIELD_BIT = 4;
    localparam int POL_GS_BIT = 3;
    localparam int POL_GSEL_LSB = 1;
    localparam int POL_CKINV_BIT = 0;
    // clock and format register fields
    localparam int CF_CKSEL_LSB = 6;
    localparam int CF_DRIVE_LSB = 4;
    localparam int CF_MODE_LSB = 2;
    localparam int CF_PRI_BIT = 1;
    localparam int CF_SEC_BIT = 0;
    // three-state register fields
    localparam int TRI_ALL_BIT = 7;
    localparam int TRI_GS_BIT = 6;
    localparam int TRI_SPDIF_BIT = 5;
    localparam int TRI_I2S_BIT = 4;
    localparam logic [7:0] TRI_MASK = 8'hF0;
    // reset values
    localparam logic [7:0] RST_POL = 8'hFE;
    localparam logic [7:0] RST_CKFMT = 8'h72;
    localparam logic [7:0] RST_TRI = 8'h00;

    typedef enum logic [1:0] {
        MODE_RGB444 = 2'b00,
        MODE_YC422 = 2'b01,
        MODE_DDR444 = 2'b10,
        MODE_YC12 = 2'b11
    } vofc_mode_t;

    typedef enum logic [1:0] {
        CK_HALF = 2'b00,
        CK_ONE = 2'b01,
        CK_TWO = 2'b10,
        CK_QUAD = 2'b11
    } vofc_cksel_t;

    typedef struct packed {
        logic [7:0] pol;
        logic [7:0] ckfmt;
        logic [7:0] tstate;
    } vofc_cfg_t;

    typedef struct packed {
        logic [23:0] pix;
        logic active_video_flag;
        logic field;
        logic frame_sync;
    } vofc_vid_t;

    // candidate sources for the green sync pin, in select order
    typedef struct packed {
        logic pll_sync;
        logic regen_sync;
        logic line_raw;
        logic slicer_raw;
    } vofc_gsrc_t;

    localparam vofc_cfg_t CFG_RST = '{pol: RST_POL, ckfmt: RST_CKFMT,
                                      tstate: RST_TRI};

    function automatic logic [11:0] vofc_addr(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction

    // level shown at a pin for a given active level setting
    function automatic logic vofc_pol(input logic sig, input logic act_hi);
        return sig ^ ~act_hi;
    endfunction
endpackage
`default_nettype wire

// >>> vofc_sink.sv
// partner: downstream capture logic sampling the pixel bus on both edges
`timescale 1ns/10ps
`default_nettype none
module vofc_sink (
    // capture clock and upper data
    input wire logic clk_pin,
    input wire logic [11:0] data,
    // values looked for, and a clear
    input wire logic [11:0] want_hi,
    input wire logic [11:0] want_lo,
    input wire logic clr,
    // sticky sightings
    output logic seen_hi,
    output logic seen_lo
);
    // ddr data is only whole if both edges capture it
    always @(posedge clk_pin or negedge clk_pin or posedge clr) begin
        if (clr) begin
            seen_hi <= 1'b0;
            seen_lo <= 1'b0;
        end else begin
            if (data == want_hi) seen_hi <= 1'b1;
            if (data == want_lo) seen_lo <= 1'b1;
        end
    end
endmodule // vofc_sink
`default_nettype wire

// >>> vofc_top.sv
// module: APB register file and link-clock pixel output formatter
`timescale 1ns/10ps
`default_nettype none
module vofc_top
    import vofc_pkg::*;
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link side: four times the pixel rate
    input wire logic link_clk,
    input wire vofc_vid_t vid_in,
    input wire vofc_gsrc_t gsrc_in,
    input wire logic spdif_in,
    input wire logic [3:0] i2s_in,
    // pixel bus: [23:8] primary, [7:0] secondary
    output logic [23:0] pix_out,
    output logic pri_oe,
    output logic sec_oe,
    // control outputs
    output logic active_video_flag,
    output logic field_out,
    output logic frame_sync_out_pin,
    output logic ctl_oe,
    output logic pixel_clock_out_pin,
    output logic clk_oe,
    output logic green_sync_out_pin,
    output logic gsync_oe,
    // audio pins
    output logic spdif_out,
    output logic spdif_oe,
    output logic [3:0] i2s_out,
    output logic i2s_oe,
    output logic [1:0] drive_strength
);
    typedef struct packed {
        vofc_cfg_t cfg;
        vofc_cfg_t hold;
        logic req;
        logic pending;
        logic [1:0] ack_s;
        logic [31:0] rdata;
        logic rdy;
        logic err;
    } vofc_apb_t;

    typedef struct packed {
        logic [1:0] req_s;
        logic ack;
        logic loaded;
        vofc_cfg_t cfg;
        logic [2:0] ph;
        logic [23:0] lat;
        logic [23:0] pix;
        logic pri_oe;
        logic sec_oe;
        logic de;
        logic field;
        logic fs;
        logic ctl_oe;
        logic ck;
        logic ck_oe;
        logic gs;
        logic gs_oe;
        logic spdif;
        logic spdif_oe;
        logic [3:0] i2s;
        logic i2s_oe;
    } vofc_lnk_t;

    vofc_apb_t a_reg, a_next;
    vofc_lnk_t l_reg, l_next;
    logic [1:0] lrst_reg;
    logic lrst_n;
    logic ack_link;
    logic busy;

    assign lrst_n = lrst_reg[1];
    assign ack_link = l_reg.ack;
    assign busy = a_reg.req ^ a_reg.ack_s[1];

    // apb domain: decode, register storage, launch of config words
    always_comb begin
        a_next = a_reg;
        a_next.ack_s = {a_reg.ack_s[0], ack_link};
        // setup phase answers on the next edge, zero wait
        if (psel && !penable) begin
            a_next.rdy = 1'b1;
            a_next.err = 1'b0;
            a_next.rdata = 32'h0000_0000;
            if (paddr == vofc_addr(IDX_POL)) begin
                a_next.rdata = {24'h00_0000, a_reg.cfg.pol};
            end else if (paddr == vofc_addr(IDX_CKFMT)) begin
                a_next.rdata = {24'h00_0000, a_reg.cfg.ckfmt};
            end else if (paddr == vofc_addr(IDX_TRI)) begin
                a_next.rdata = {24'h00_0000, a_reg.cfg.tstate};
            end else if (paddr == vofc_addr(IDX_STAT)) begin
                a_next.rdata = {31'h0000_0000, busy | a_reg.pending};
            end else begin
                a_next.err = 1'b1; // unmapped address
            end
        end else begin
            a_next.rdy = 1'b0;
            a_next.err = 1'b0;
        end
        // one word in flight; it stays frozen until the link acknowledges
        if (!busy && a_reg.pending) begin
            a_next.hold = a_reg.cfg;
            a_next.req = ~a_reg.req;
            a_next.pending = 1'b0;
        end
        // write lands after the launch so a same-cycle write stays pending
        if (psel && penable && a_reg.rdy && pwrite && !a_reg.err) begin
            if (paddr == vofc_addr(IDX_POL)) begin
                a_next.cfg.pol = pwdata[7:0];
                a_next.pending = 1'b1;
            end else if (paddr == vofc_addr(IDX_CKFMT)) begin
                a_next.cfg.ckfmt = pwdata[7:0];
                a_next.pending = 1'b1;
            end else if (paddr == vofc_addr(IDX_TRI)) begin
                a_next.cfg.tstate = pwdata[7:0] & TRI_MASK;
                a_next.pending = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_reg <= '{cfg: CFG_RST, hold: CFG_RST, req: 1'b0,
                       pending: 1'b0, ack_s: 2'b00, rdata: 32'h0000_0000,
                       rdy: 1'b0, err: 1'b0};
        end else begin
            a_reg <= a_next;
        end
    end

    // reset release is retimed into the link domain
    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            lrst_reg <= 2'b00;
        end else begin
            lrst_reg <= {lrst_reg[0], 1'b1};
        end
    end

    // link domain: pixel phase, formatting and pin enables
    always_comb begin
        logic pix_end;
        logic half_end;
        logic new_cfg;
        logic [2:0] nph;
        logic ck_raw;
        logic tri_all;
        logic sec_mode;
        vofc_mode_t mode;
        vofc_cksel_t cksel;
        pix_end = 1'b0;
        half_end = 1'b0;
        new_cfg = 1'b0;
        nph = 3'b000;
        ck_raw = 1'b0;
        tri_all = 1'b0;
        sec_mode = 1'b0;
        mode = MODE_RGB444;
        cksel = CK_ONE;
        l_next = l_reg;
        l_next.req_s = {l_reg.req_s[0], a_reg.req};
        pix_end = (l_reg.ph[1:0] == 2'b11);
        half_end = (l_reg.ph[1:0] == 2'b01);
        nph = l_reg.ph + 3'b001;
        l_next.ph = nph;
        // new settings only at a pixel boundary so no pin glitches mid-pixel
        new_cfg = (l_reg.req_s[1] != l_reg.ack) && pix_end;
        if (new_cfg) begin
            l_next.cfg = a_reg.hold; // word held stable until ack returns
            l_next.ack = l_reg.req_s[1];
        end
        l_next.loaded = new_cfg;
        mode = vofc_mode_t'(l_reg.cfg.ckfmt[CF_MODE_LSB +: 2]);
        cksel = vofc_cksel_t'(l_reg.cfg.ckfmt[CF_CKSEL_LSB +: 2]);
        tri_all = l_reg.cfg.tstate[TRI_ALL_BIT];
        sec_mode = (mode == MODE_YC422) || (mode == MODE_DDR444);
        // output clock built from the phase counter; uninverted and not at half rate, it is low as each pixel starts
        unique case (cksel)
            CK_HALF: ck_raw = nph[2];
            CK_ONE: ck_raw = nph[1];
            CK_TWO: ck_raw = nph[0];
            CK_QUAD: ck_raw = nph[1] ^ nph[0];
        endcase
        l_next.ck = ck_raw ^ l_reg.cfg.pol[POL_CKINV_BIT];
        // first half of each pixel, taken at the pixel boundary
        if (pix_end) begin
            l_next.lat = vid_in.pix;
            l_next.de = vofc_pol(vid_in.active_video_flag,
                                 l_reg.cfg.pol[POL_DE_BIT]);
            // field input high means odd; polarity 1 swaps the levels
            l_next.field = vofc_pol(vid_in.field,
                                    ~l_reg.cfg.pol[POL_FIELD_BIT]);
            l_next.fs = vofc_pol(vid_in.frame_sync,
                                 l_reg.cfg.pol[POL_FRAME_BIT]);
            unique case (mode)
                MODE_RGB444, MODE_YC12: begin
                    // 12-bit 4:2:2 laid out on 24 pins; valid from HDMI only
                    l_next.pix = vid_in.pix;
                end
                MODE_YC422: begin
                    l_next.pix = {vid_in.pix[23:8], vid_in.pix[23:16]};
                end
                MODE_DDR444: begin
                    l_next.pix = {vid_in.pix[23:12], 4'h0,
                                  vid_in.pix[23:16]};
                end
            endcase
        end else if (half_end && sec_mode) begin
            // second half lands on the opposite clock edge
            if (mode == MODE_DDR444) begin
                l_next.pix = {l_reg.lat[11:0], 4'h0, l_reg.lat[15:8]};
            end else begin
                l_next.pix = {l_reg.pix[23:8], l_reg.lat[15:8]};
            end
        end
        // green sync pin keeps running even when the rest floats
        unique case (l_reg.cfg.pol[POL_GSEL_LSB +: 2])
            2'b00: l_next.gs = gsrc_in.slicer_raw;
            2'b01: l_next.gs = gsrc_in.line_raw;
            2'b10: l_next.gs = gsrc_in.regen_sync;
            2'b11: l_next.gs = gsrc_in.pll_sync;
        endcase
        l_next.gs = vofc_pol(l_next.gs, l_reg.cfg.pol[POL_GS_BIT]);
        l_next.gs_oe = ~l_reg.cfg.tstate[TRI_GS_BIT];
        // enables; primary also covers blue outside the split modes
        l_next.ctl_oe = ~tri_all;
        l_next.ck_oe = ~tri_all;
        l_next.pri_oe = l_reg.cfg.ckfmt[CF_PRI_BIT] & ~tri_all;
        l_next.sec_oe = (sec_mode ? l_reg.cfg.ckfmt[CF_SEC_BIT]
                                  : l_reg.cfg.ckfmt[CF_PRI_BIT])
                        & ~tri_all;
        l_next.spdif = spdif_in;
        l_next.spdif_oe = ~tri_all & ~l_reg.cfg.tstate[TRI_SPDIF_BIT];
        l_next.i2s = i2s_in;
        l_next.i2s_oe = ~tri_all & ~l_reg.cfg.tstate[TRI_I2S_BIT];
    end

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            l_reg <= '{req_s: 2'b00, ack: 1'b0, loaded: 1'b0, cfg: CFG_RST,
                       ph: 3'b000, lat: 24'h00_0000, pix: 24'h00_0000,
                       pri_oe: 1'b0, sec_oe: 1'b0, de: 1'b0, field: 1'b0,
                       fs: 1'b0, ctl_oe: 1'b0, ck: 1'b0, ck_oe: 1'b0,
                       gs: 1'b0, gs_oe: 1'b0, spdif: 1'b0, spdif_oe: 1'b0,
                       i2s: 4'h0, i2s_oe: 1'b0};
        end else begin
            l_reg <= l_next;
        end
    end

    // every output straight from a flip-flop
    assign prdata = a_reg.rdata;
    assign pready = a_reg.rdy;
    assign pslverr = a_reg.err;
    assign pix_out = l_reg.pix;
    assign pri_oe = l_reg.pri_oe;
    assign sec_oe = l_reg.sec_oe;
    assign active_video_flag = l_reg.de;
    assign field_out = l_reg.field;
    assign frame_sync_out_pin = l_reg.fs;
    assign ctl_oe = l_reg.ctl_oe;
    assign pixel_clock_out_pin = l_reg.ck;
    assign clk_oe = l_reg.ck_oe;
    assign green_sync_out_pin = l_reg.gs;
    assign gsync_oe = l_reg.gs_oe;
    assign spdif_out = l_reg.spdif;
    assign spdif_oe = l_reg.spdif_oe;
    assign i2s_out = l_reg.i2s;
    assign i2s_oe = l_reg.i2s_oe;
    assign drive_strength = l_reg.cfg.ckfmt[CF_DRIVE_LSB +: 2];
endmodule // vofc_top
`default_nettype wire

// >>> vofc_top_tb.sv
// testbench: registers, pin polarity, clock select, modes and three-state
`timescale 1ns/10ps
`default_nettype none
module vofc_top_tb;
    import vofc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, link_clk;
    logic pri_oe, sec_oe, ctl_oe, clk_oe, gsync_oe, spdif_oe, i2s_oe, clr;
    logic active_video_flag, field_out, frame_sync_out_pin, spdif_out;
    logic pixel_clock_out_pin, green_sync_out_pin, spdif_in, seen_hi, seen_lo;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_data, rnd;
    logic [23:0] pix_out, pix;
    logic [3:0] i2s_in, i2s_out;
    logic [1:0] drive_strength;
    logic [7:0] tv[5] = '{8'hF0, 8'h80, 8'h40, 8'h20, 8'h10};
    vofc_vid_t vid_in;
    vofc_gsrc_t gsrc_in;
    logic [32:0] exp_q[$];
    int num_errors, compares, n, k;
    logic prev;

    vofc_top i_vofc_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .link_clk, .vid_in, .gsrc_in,
        .spdif_in, .i2s_in, .pix_out, .pri_oe, .sec_oe, .active_video_flag,
        .field_out, .frame_sync_out_pin, .ctl_oe, .pixel_clock_out_pin,
        .clk_oe, .green_sync_out_pin, .gsync_oe, .spdif_out, .spdif_oe,
        .i2s_out, .i2s_oe, .drive_strength);
    vofc_sink i_vofc_sink (.clk_pin(pixel_clock_out_pin),
        .data(pix_out[23:12]), .want_hi(pix[23:12]), .want_lo(pix[11:0]),
        .clr, .seen_hi, .seen_lo);

    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end
    // link clock kept out of step with the bus clock
    initial begin
        link_clk = 0;
        #13;
        forever #40 link_clk = ~link_clk;
    end

    task check(string what, logic [32:0] seen, logic [32:0] want);
        compares++;
        if (seen !== want) begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", what, want, seen);
        end
    endtask
    task final_report;
        if (num_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one transfer; a checked read leaves its expectation for the watcher
    task apb(logic w, logic [11:0] a, logic [7:0] d, logic c, logic [32:0] e);
        n = 0;
        if (c) exp_q.push_back(e);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_data = prdata;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1) begin
            num_errors++;
            final_report;
        end
    endtask
    task wr(logic [9:0] idx, logic [7:0] d);
        apb(1, {idx, 2'b00}, d, 0, 0);
    endtask
    task rd(logic [9:0] idx, logic [32:0] e);
        apb(0, {idx, 2'b00}, 0, 1, e);
    endtask
    // new settings cross domains: wait for status, then two pixels
    task settle;
        for (int i = 0; i < 40; i++) begin
            apb(0, {IDX_STAT, 2'b00}, 0, 0, 0);
            if (rd_data[0] === 1'b0) break;
        end
        if (rd_data[0] !== 1'b0) begin
            num_errors++;
            final_report;
        end
        repeat (8) @(negedge link_clk);
    endtask

    // watcher pairs each answered read with the oldest expectation
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
            check("apb read", {pslverr, prdata}, exp_q.pop_front());

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, clr} = '0;
        {spdif_in, i2s_in, num_errors, compares} = '0;
        gsrc_in = 4'b1000;
        rnd = $urandom(32'hE65F);
        pix = rnd[23:0];
        pix[11:0] = ~pix[23:12];
        vid_in = {pix, 3'b111};
        repeat (4) @(posedge pclk);
        presetn <= 1;
        rd(IDX_POL, 33'h0FE);
        rd(IDX_CKFMT, 33'h072);
        rd(IDX_TRI, 33'h000);
        rd(10'h028, 33'h100000000);
        rnd = $urandom;
        wr(IDX_POL, rnd[7:0]);
        rd(IDX_POL, {25'h0, rnd[7:0]});
        wr(IDX_TRI, rnd[15:8]);
        rd(IDX_TRI, {25'h0, rnd[15:12], 4'h0});
        wr(IDX_POL, RST_POL);
        wr(IDX_TRI, 8'h00);
        settle;
        check("pins", {active_video_flag, field_out, frame_sync_out_pin,
            green_sync_out_pin, drive_strength}, 6'b101111);
        // audio pins pass straight through while not floated
        @(posedge link_clk);
        spdif_in <= rnd[16];
        i2s_in <= rnd[20:17];
        repeat (2) @(negedge link_clk);
        check("audio", {spdif_out, i2s_out}, {rnd[16], rnd[20:17]});
        // every green sync source, every polarity low
        for (int s = 0; s < 4; s++) begin
            wr(IDX_POL, {5'b00000, s[1:0], 1'b0});
            gsrc_in <= vofc_gsrc_t'(4'b0001 << s);
            settle;
            check("pins low", {active_video_flag, field_out,
                frame_sync_out_pin, green_sync_out_pin},
                4'b0100);
        end
        for (int c = 0; c < 4; c++) begin
            wr(IDX_CKFMT, {c[1:0], 6'b111010});
            settle;
            k = 0;
            @(negedge link_clk) prev = pixel_clock_out_pin;
            repeat (32) @(negedge link_clk) begin
                if (pixel_clock_out_pin && !prev) k++;
                prev = pixel_clock_out_pin;
            end
            check("clock rises", k, c == 0 ? 4 : c == 2 ? 16 : 8);
        end
        // in ddr mode the uninverted 1x clock is low while the first half stands, high when inverted
        for (int v = 0; v < 2; v++) begin
            wr(IDX_CKFMT, 8'h7A);
            wr(IDX_POL, {RST_POL[7:1], v[0]});
            settle;
            repeat (8) @(negedge link_clk) check("clock phase",
                pixel_clock_out_pin,
                (pix_out[23:12] == pix[11:0]) ^ v[0]);
        end
        // 12-bit mode taken as if the digital input were in use
        for (int m = 0; m < 4; m++) begin
            wr(IDX_CKFMT, {4'b1101, m[1:0], 2'b10});
            clr <= 1;
            settle;
            clr <= 0;
            repeat (8) @(negedge link_clk);
            check("mode", {seen_hi, seen_lo, sec_oe, pri_oe, drive_strength},
                {1'b1, m == 2, m == 0 || m == 3,
                3'b101});
            if (m != 2) check("primary", pix_out[23:8], pix[23:8]);
            if (m == 0 || m == 3) check("blue", pix_out[7:0], pix[7:0]);
        end
        wr(IDX_CKFMT, 8'h45);
        settle;
        check("enables", {pri_oe, sec_oe, drive_strength},
            4'b0100);
        for (int i = 0; i < 5; i++) begin
            wr(IDX_TRI, tv[i]);
            settle;
            check("floats", {ctl_oe, clk_oe, gsync_oe, spdif_oe, i2s_oe},
                {~tv[i][7], ~tv[i][7], ~tv[i][6], ~(tv[i][7] | tv[i][5]),
                ~(tv[i][7] | tv[i][4])});
        end
        final_report;
    end
    initial begin
        #1500000;
        num_errors++;
        final_report;
    end
endmodule // vofc_top_tb
`default_nettype wire
